// File: xfs_arc_if.sv
// Link between the supervisor and its arc-rate window
interface xfs_arc_if;
    logic ms_tick;
    logic arc_pulse;
    logic trip;
    modport supervisor (output ms_tick, output arc_pulse, input trip);
    modport window (input ms_tick, input arc_pulse, output trip);
endinterface

// File: xfs_arc_window.sv
// Arc-rate window: trips when an arc lands with three others inside the window
module xfs_arc_window import xfs_pkg::*; #(
    parameter int WIN_MS = ARC_WIN_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Arc events in, trip out
    xfs_arc_if.window arc_bus
);
    localparam int SLOTS = ARC_TRIP_COUNT - 1;

    // Ages of the last three arcs, newest first, saturating at the window
    typedef struct packed {
        logic [SLOTS-1:0][MS_W-1:0] age;
        logic trip;
    } xfs_arc_state_type;

    xfs_arc_state_type st, next_st;

    // Age the slots and shift in new arcs
    always_comb begin
        next_st = st;
        next_st.trip = 1'b0;
        if (arc_bus.arc_pulse) begin
            // R14: fourth arc in window
            next_st.trip = (st.age[SLOTS-1] < MS_W'(WIN_MS));
            for (int i = SLOTS - 1; i > 0; i--) begin
                next_st.age[i] = st.age[i-1];
            end
            next_st.age[0] = '0;
        end else if (arc_bus.ms_tick) begin
            // R24: aged by millisecond tick
            for (int i = 0; i < SLOTS; i++) begin
                if (st.age[i] < MS_W'(WIN_MS)) begin
                    next_st.age[i] = st.age[i] + 1'b1;
                end
            end
        end
    end

    // Reset leaves every slot stale so old arcs never count
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= {{SLOTS{MS_W'(WIN_MS)}}, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign arc_bus.trip = st.trip;

    trip_needs_arc_a: assert property (@(posedge mclk) disable iff (sys_rst) // R14
        arc_bus.trip |-> $past(arc_bus.arc_pulse))
        else $error("arc trip without an arc");
endmodule

// File: xfs_host_model.sv
// Host computer model: issues register commands and reads one strobe at a time
module xfs_host_model (
    // Clock
    input wire logic mclk,
    // Register port toward the supervisor
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // host supplies on, off and clear commands
    // Address and data are scrambled once released so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // One read strobe; the data come back in the following cycle only
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule

// File: xfs_ms_tick.sv
// Millisecond enable pulse divided down from the system clock
module xfs_ms_tick import xfs_pkg::*; #(
    parameter int CYCLES = CYC_PER_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // One-cycle pulse each millisecond
    output logic ms_tick
);
    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic tick;
    } xfs_tick_state_type;

    xfs_tick_state_type st, next_st;

    // Count down and pulse on wrap
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == '0) begin
            next_st.cnt = TICK_W'(CYCLES - 1);
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ms_tick = st.tick;
endmodule

// File: xfs_pkg.sv
// Shared constants and types for the X-ray fault supervisor
package xfs_pkg;
    // Clock and time base
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int TICK_W = 17;
    localparam int MS_W = 14;
    // Host silence allowed before the watchdog trips
    localparam int WDOG_S = 10;
    localparam int WDOG_MS = WDOG_S * MS_PER_S;
    // Arc window, trip count and single-arc lamp pulse
    localparam int ARC_WIN_S = 10;
    localparam int ARC_WIN_MS = ARC_WIN_S * MS_PER_S;
    localparam int ARC_LAMP_S = 1;
    localparam int ARC_LAMP_MS = ARC_LAMP_S * MS_PER_S;
    localparam int ARC_TRIP_COUNT = 4;
    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_KV_SET = 8'h04;
    localparam logic [7:0] OFS_MA_SET = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_CODE = 8'h14;
    localparam logic [7:0] OFS_KV_RD = 8'h18;
    localparam logic [7:0] OFS_MA_RD = 8'h1C;
    localparam logic [7:0] OFS_FIL_RD = 8'h20;
    localparam logic [7:0] OFS_OIL_RD = 8'h24;
    // Control register command bits
    localparam int CTL_ON = 0;
    localparam int CTL_OFF = 1;
    localparam int CTL_CLEAR = 2;
    localparam int CTL_ARM = 3;
    localparam int CTL_DISARM = 4;
    // Status register bits
    localparam int ST_HV = 0;
    localparam int ST_INTLK = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_DIGITAL = 3;
    localparam int ST_WDOG = 4;
    // Fault flag positions; pins 0..5 share the same positions
    localparam int FLT_OV = 0;
    localparam int FLT_OC = 1;
    localparam int FLT_UV = 2;
    localparam int FLT_UC = 3;
    localparam int FLT_OT = 4;
    localparam int FLT_OP = 5;
    localparam int FLT_ARC = 6;
    localparam int FLT_WD = 7;
    localparam int FLT_IL = 8;
    localparam int FLT_N = 9;
    localparam int PIN_ARC = 6;
    localparam int PIN_IL = 7;
    localparam int PIN_LOCAL = 8;
    localparam int PIN_N = 9;
    // Faults that force the power-down state (not undercurrent, not overpower)
    localparam logic [8:0] SHUT_MASK = 9'h1D7;
    // Fault argument codes
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_ARC = 4'h1;
    localparam logic [3:0] CODE_OV = 4'h3;
    localparam logic [3:0] CODE_UV = 4'h4;
    localparam logic [3:0] CODE_OC = 4'h5;
    localparam logic [3:0] CODE_WD = 4'h5;
    localparam logic [3:0] CODE_UC = 4'h6;
    localparam logic [3:0] CODE_OT = 4'h6;
    localparam logic [3:0] CODE_IL = 4'h8;
    localparam logic [3:0] CODE_OP = 4'h9;
    // Reset values
    localparam logic [15:0] SETPOINT_RST = 16'h0000;
    // Output state of the supervisor
    typedef enum logic [1:0] {
        XFS_OFF = 2'b00,
        XFS_ON = 2'b01,
        XFS_DOWN = 2'b10
    } xfs_mode_type;
endpackage

// File: xfs_supervisor.sv
// Top of the X-ray fault supervisor: enable control, fault latching and host registers

// How it works
// R1: Any internal fault latches, lamps, forces off; undercurrent and overpower latch and lamp but keep output on
// R2: Armed watchdog stops output after 10 s
// R3: Watchdog expiry latches, reports code 5
// R4: Setpoints clear to zero at power-up
// R5: Enable from host command or local contact
// R6: Local contact ignored after first digital enable
// R7: Interlock open refuses or drops high voltage
// R8: Open interlock reported as code 8 only
// R9: Shutdown fault enters power-down, lamp off
// R10: Fault held until clear or on command
// R11: Overvoltage trips, lamps, reports code 3
// R12: Overcurrent trips, lamps, reports code 5
// R13: Single arc pulses lamp 1 s, code 1
// R14: Four arcs in 10 s trip off
// R15: Undervoltage trips, lamps, reports code 4
// R16: Undercurrent lamps, code 6, keeps output on
// R17: Overtemperature trips, lamps, reports code 6
// R18: Overpower lights both current lamps, code 9
// R19: Relay energised while output is on
// R20: Fault output open-collector, high when clean
// R21: X-ray indication open-collector, high when off
// R22: Readings available to host on request
// R23: Separate latched flag for every fault
// R24: All timers run from millisecond tick
module xfs_supervisor import xfs_pkg::*; #(
    parameter int CYC_PER_MS_P = CYC_PER_MS,
    parameter int WDOG_MS_P = WDOG_MS,
    parameter int ARC_WIN_MS_P = ARC_WIN_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Comparator fault inputs, asynchronous
    input wire logic overvoltage_fault,
    input wire logic overcurrent_fault,
    input wire logic undervoltage_fault,
    input wire logic undercurrent_fault,
    input wire logic overtemperature_fault,
    input wire logic overpower_fault,
    input wire logic arc_detect,
    // Contacts, asynchronous
    input wire logic interlock_closed,
    input wire logic local_enable,
    // Digitised readings, same clock
    input wire logic [15:0] kv_reading,
    input wire logic [15:0] ma_reading,
    input wire logic [15:0] fil_reading,
    input wire logic [15:0] oil_reading,
    // Setpoints to the regulators
    output logic [15:0] kv_setpoint,
    output logic [15:0] ma_setpoint,
    // Output enable and relay
    output logic high_voltage_output,
    output logic relay_coil,
    // Lamps
    output logic lamp_ov,
    output logic lamp_oc,
    output logic lamp_uv,
    output logic lamp_uc,
    output logic lamp_ot,
    output logic arc_event_lamp,
    output logic xray_on_lamp,
    // Open-collector outputs: pulled low while enable is high
    output logic ps_fault_out,
    output logic ps_fault_oe,
    output logic xray_ind_out,
    output logic xray_ind_oe
);
    // Entire supervisor state
    typedef struct packed {
        logic [PIN_N-1:0] s1;
        logic [PIN_N-1:0] s2;
        logic arc_prev;
        xfs_mode_type mode;
        logic digital;
        logic wd_armed;
        logic [MS_W-1:0] wd_cnt;
        logic [FLT_N-1:0] flags;
        logic [3:0] code;
        logic [MS_W-1:0] lamp_cnt;
        logic [15:0] kv_set;
        logic [15:0] ma_set;
        logic [31:0] rdata;
    } xfs_state_type;

    xfs_state_type st, next_st;

    logic ms_tick; // Millisecond enable
    logic arc_rise; // One-cycle arc event
    logic wr_ctl; // Control register write
    logic cmd_on, cmd_off, cmd_clear;
    logic clear; // Fault reset request
    logic host_act; // Any host access feeds the watchdog
    logic wd_expire; // Watchdog past its limit
    logic [FLT_N-1:0] ev; // Fault events this cycle
    logic [FLT_N-1:0] kept; // Flags surviving a clear
    logic fault_now; // Shutdown fault present after this cycle
    logic on_req, off_req;
    logic [31:0] rd_mux;

    xfs_arc_if arc_bus ();

    // R24: one shared millisecond tick
    xfs_ms_tick #(.CYCLES(CYC_PER_MS_P)) u_tick (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ms_tick(ms_tick)
    );

    xfs_arc_window #(.WIN_MS(ARC_WIN_MS_P)) u_arc (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .arc_bus(arc_bus)
    );

    assign arc_bus.ms_tick = ms_tick;
    assign arc_bus.arc_pulse = arc_rise;

    // Highest-priority code among new events; shutdown causes and a lone arc come before overpower and undercurrent
    function automatic logic [3:0] code_of(input logic [FLT_N-1:0] e, input logic arc1);
        if (e[FLT_OV]) begin
            return CODE_OV;
        end else if (e[FLT_OC]) begin
            return CODE_OC;
        end else if (e[FLT_UV]) begin
            return CODE_UV;
        end else if (e[FLT_OT]) begin
            return CODE_OT;
        end else if (e[FLT_ARC] || arc1) begin
            return CODE_ARC;
        end else if (e[FLT_WD]) begin
            return CODE_WD;
        end else if (e[FLT_IL]) begin
            return CODE_IL;
        end else if (e[FLT_OP]) begin
            return CODE_OP;
        end else if (e[FLT_UC]) begin
            return CODE_UC;
        end
        return CODE_NONE;
    endfunction

    // Decode of host commands and events
    always_comb begin
        arc_rise = st.s2[PIN_ARC] & ~st.arc_prev;
        wr_ctl = reg_wr && (reg_addr == OFS_CONTROL);
        cmd_on = wr_ctl & reg_wdata[CTL_ON];
        cmd_off = wr_ctl & reg_wdata[CTL_OFF];
        cmd_clear = wr_ctl & reg_wdata[CTL_CLEAR];
        // R10: on command also resets faults
        clear = cmd_on | cmd_clear;
        host_act = reg_wr | reg_rd;
        // R2: strictly longer than the limit
        wd_expire = st.wd_armed && (st.wd_cnt > MS_W'(WDOG_MS_P));
        // R1: comparator inputs become events
        ev = '0;
        ev[FLT_OP:FLT_OV] = st.s2[FLT_OP:FLT_OV];
        // R14: arc-rate trip
        ev[FLT_ARC] = arc_bus.trip;
        // R3: watchdog expiry is a fault
        ev[FLT_WD] = wd_expire;
        // R7: open interlock is a fault
        ev[FLT_IL] = ~st.s2[PIN_IL];
        kept = clear ? '0 : st.flags;
        // R9: any shutdown fault forces power-down
        fault_now = |((kept | ev) & SHUT_MASK);
        // R5: host command or local contact
        // R6: contact has no say once digital
        on_req = cmd_on | (~st.digital & st.s2[PIN_LOCAL]);
        off_req = cmd_off | (~st.digital & ~cmd_on & ~st.s2[PIN_LOCAL]);
    end

    // Read multiplexer
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_addr)
            OFS_KV_SET: rd_mux[15:0] = st.kv_set;
            OFS_MA_SET: rd_mux[15:0] = st.ma_set;
            OFS_STATUS: begin
                rd_mux[ST_HV] = (st.mode == XFS_ON);
                rd_mux[ST_INTLK] = st.s2[PIN_IL];
                rd_mux[ST_FAULT] = |st.flags;
                rd_mux[ST_DIGITAL] = st.digital;
                rd_mux[ST_WDOG] = st.wd_armed;
            end
            // R23: one flag per fault
            OFS_FLAGS: rd_mux[FLT_N-1:0] = st.flags;
            OFS_CODE: rd_mux[3:0] = st.code;
            // R22: readings on request
            OFS_KV_RD: rd_mux[15:0] = kv_reading;
            OFS_MA_RD: rd_mux[15:0] = ma_reading;
            OFS_FIL_RD: rd_mux[15:0] = fil_reading;
            OFS_OIL_RD: rd_mux[15:0] = oil_reading;
            // Control is write-only; unmapped reads give zero
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Next state
    always_comb begin
        next_st = st;
        // Two-flop synchronisers; only s2 is looked at
        next_st.s1 = {local_enable, interlock_closed, arc_detect, overpower_fault,
                      overtemperature_fault, undercurrent_fault, undervoltage_fault,
                      overcurrent_fault, overvoltage_fault};
        next_st.s2 = st.s1;
        next_st.arc_prev = st.s2[PIN_ARC];
        // R1: set wins over a clear in the same cycle
        next_st.flags = kept | ev;
        // Code follows the newest event; a lone arc also reports
        if (|(ev & ~kept) || arc_rise) begin
            // R11: code 3 / R12: code 5 / R15: code 4 / R17: code 6
            // R8: code 8 / R18: code 9 / R16: code 6
            next_st.code = code_of(ev & ~kept, arc_rise);
        end else if (clear) begin
            next_st.code = CODE_NONE;
        end
        // R13: one-second arc lamp
        if (arc_rise) begin
            next_st.lamp_cnt = MS_W'(ARC_LAMP_MS);
        end else if (ms_tick && st.lamp_cnt != '0) begin
            next_st.lamp_cnt = st.lamp_cnt - 1'b1;
        end
        // R2: watchdog arming and silence count
        if (wr_ctl && reg_wdata[CTL_ARM]) begin
            next_st.wd_armed = 1'b1;
        end else if (wr_ctl && reg_wdata[CTL_DISARM]) begin
            next_st.wd_armed = 1'b0;
        end
        if (host_act || !st.wd_armed) begin
            next_st.wd_cnt = '0;
        end else if (ms_tick && !wd_expire) begin
            next_st.wd_cnt = st.wd_cnt + 1'b1;
        end
        // R6: first digital enable latches remote mode
        if (cmd_on) begin
            next_st.digital = 1'b1;
        end
        // Setpoint writes
        if (reg_wr && reg_addr == OFS_KV_SET) begin
            next_st.kv_set = reg_wdata[15:0];
        end
        if (reg_wr && reg_addr == OFS_MA_SET) begin
            next_st.ma_set = reg_wdata[15:0];
        end
        // Read data stands one cycle only
        next_st.rdata = reg_rd ? rd_mux : 32'h0000_0000;
        // Output mode
        unique case (st.mode)
            XFS_OFF: begin
                // R7: refused while interlock open
                if (fault_now) begin
                    next_st.mode = XFS_DOWN;
                end else if (on_req) begin
                    next_st.mode = XFS_ON;
                end
            end
            XFS_ON: begin
                // R9: shutdown fault drops output at once
                if (fault_now) begin
                    next_st.mode = XFS_DOWN;
                end else if (off_req) begin
                    next_st.mode = XFS_OFF;
                end
            end
            XFS_DOWN: begin
                // R10: leaves only once faults are cleared
                if (!fault_now) begin
                    next_st.mode = cmd_on ? XFS_ON : XFS_OFF;
                end
            end
            default: next_st.mode = XFS_DOWN;
        endcase
    end

    // State register; synchroniser flops reset to the safe reading
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.mode <= XFS_OFF;
            // R4: setpoints zero at power-up
            st.kv_set <= SETPOINT_RST;
            st.ma_set <= SETPOINT_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs, all from flops
    assign reg_rdata = st.rdata;
    assign kv_setpoint = st.kv_set;
    assign ma_setpoint = st.ma_set;
    assign high_voltage_output = (st.mode == XFS_ON);
    // R19: relay and lamp follow output
    assign relay_coil = (st.mode == XFS_ON);
    assign xray_on_lamp = (st.mode == XFS_ON);
    assign lamp_ov = st.flags[FLT_OV];
    assign lamp_uv = st.flags[FLT_UV];
    assign lamp_ot = st.flags[FLT_OT];
    // R18: overpower shows on both current lamps
    assign lamp_oc = st.flags[FLT_OC] | st.flags[FLT_OP];
    assign lamp_uc = st.flags[FLT_UC] | st.flags[FLT_OP];
    assign arc_event_lamp = (st.lamp_cnt != '0) | st.flags[FLT_ARC];
    // R20: pulled low while any fault latched
    assign ps_fault_out = 1'b0;
    assign ps_fault_oe = |st.flags;
    // R21: pulled low while output is on
    assign xray_ind_out = 1'b0;
    assign xray_ind_oe = (st.mode == XFS_ON);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    localparam logic [MS_W-1:0] WD_LIM = MS_W'(WDOG_MS_P);

    sequence wd_expired_s;
        st.wd_armed && (st.wd_cnt > WD_LIM) && !host_act;
    endsequence

    fault_forces_off_a: assert property (st.s2[FLT_OV] |=> !high_voltage_output) // R1
        else $error("overvoltage left output on");
    wdog_stops_a: assert property (wd_expired_s |=> !high_voltage_output && st.flags[FLT_WD]) // R2
        else $error("watchdog expiry did not stop output");
    wdog_code_a: assert property (ev == 9'h080 && !arc_rise && st.flags == '0 |=>
        st.code == CODE_WD) // R3
        else $error("watchdog code wrong");
    local_ignored_a: assert property (st.digital && st.mode == XFS_OFF && !cmd_on |=>
        st.mode != XFS_ON) // R6
        else $error("local contact enabled in digital mode");
    interlock_off_a: assert property (!st.s2[PIN_IL] |=> !high_voltage_output ##1
        (!high_voltage_output || $past(st.s2[PIN_IL]))) // R7
        else $error("output on with interlock open");
    fault_held_a: assert property (st.flags[FLT_OC] && !clear |=> st.flags[FLT_OC]) // R10
        else $error("fault flag dropped without reset");
    arc_lamp_a: assert property (arc_rise |=> arc_event_lamp [*8]) // R13
        else $error("arc lamp not lit after arc");
    uc_keeps_on_a: assert property (st.mode == XFS_ON && st.digital && ev == 9'h008 &&
        !cmd_off && (st.flags & SHUT_MASK) == '0 |=> high_voltage_output) // R16
        else $error("undercurrent dropped output");
    ps_fault_a: assert property (|ev |=> ps_fault_oe) // R20
        else $error("fault output not pulled low");
endmodule

// File: xfs_supervisor_tb.sv
// Self-checking bench for the X-ray fault supervisor
module xfs_supervisor_tb import xfs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // Design ports
    logic mclk, sys_rst, reg_wr, reg_rd, arc_detect, interlock_closed, local_enable;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] kv_reading, ma_reading, fil_reading, oil_reading, kv_setpoint, ma_setpoint;
    logic high_voltage_output, relay_coil, lamp_ov, lamp_oc, lamp_uv, lamp_uc, lamp_ot;
    logic arc_event_lamp, xray_on_lamp, ps_fault_out, ps_fault_oe, xray_ind_out, xray_ind_oe;
    // Comparator faults as one vector, bit i is fault flag i
    logic [5:0] flt;
    wire logic overvoltage_fault = flt[FLT_OV];
    wire logic overcurrent_fault = flt[FLT_OC];
    wire logic undervoltage_fault = flt[FLT_UV];
    wire logic undercurrent_fault = flt[FLT_UC];
    wire logic overtemperature_fault = flt[FLT_OT];
    wire logic overpower_fault = flt[FLT_OP];
    localparam logic [3:0] CODES [6] = '{CODE_OV, CODE_OC, CODE_UV, CODE_UC, CODE_OT, CODE_OP};
    // Bench state
    int err_count = 0;
    int n_compared = 0;
    logic [31:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic [63:0] rv;

    // Short ms tick keeps the 1 s arc lamp near 10000 cycles
    xfs_supervisor #(.CYC_PER_MS_P(10), .WDOG_MS_P(20), .ARC_WIN_MS_P(30)) dut (.*);
    xfs_host_model host (.*);

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Note the expected read value, then let the host issue the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    // Wait n edges and settle past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Lamps packed so bit i is the lamp of fault i, arc lamp in bit 5
    function automatic logic [31:0] lamps();
        return {26'h0, arc_event_lamp, lamp_ot, lamp_uc, lamp_uv, lamp_oc, lamp_ov};
    endfunction

    task automatic hv_is(input logic h);
        logic [31:0] s;
        s = {28'h0, high_voltage_output, relay_coil, xray_on_lamp, xray_ind_oe};
        chk("hv", s, {28'h0, {4{h}}});
    endtask

    // n arcs, one rising edge every 30 cycles
    task automatic arc(input int n);
        repeat (n) begin
            @(posedge mclk) arc_detect <= 1'b1;
            repeat (3) @(posedge mclk);
            arc_detect <= 1'b0;
            cyc(26);
        end
    endtask

    // Read data stand only in the cycle after the strobe, so compare mid-cycle
    always @(posedge mclk) rd_pend <= reg_rd;
    always @(negedge mclk) begin
        if (rd_pend) begin
            chk("rdata", reg_rdata, exp_q.pop_front());
        end
    end

    // Hang guard, well beyond the planned 11000 cycles
    initial begin
        #300_000;
        err_count++;
        end_of_test();
    end

    initial begin
        sys_rst = 1'b1;
        flt = 6'h00;
        arc_detect = 1'b0;
        interlock_closed = 1'b0;
        local_enable = 1'b0;
        {kv_reading, ma_reading, fil_reading, oil_reading} = 64'h0;
        void'($urandom(32'h1bc7));
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        cyc(4);
        // Power-up: setpoints zero, open interlock only as a code
        chk("kv_set", {16'h0, kv_setpoint}, 32'h0);
        chk("lamps", lamps(), 32'h0);
        chk("oc_pins", {30'h0, ps_fault_out, xray_ind_out}, 32'h0);
        rd(OFS_MA_SET, 32'h0);
        rd(OFS_FLAGS, 32'h1 << FLT_IL);
        rd(OFS_CODE, {28'h0, CODE_IL});
        @(posedge mclk) interlock_closed <= 1'b1;
        cyc(4);
        host.wr(OFS_CONTROL, 32'h1 << CTL_CLEAR);
        cyc(2);
        chk("ps_fault", {31'h0, ps_fault_oe}, 32'h0);
        // Local contact rules only until the first host on command
        @(posedge mclk) local_enable <= 1'b1;
        cyc(4);
        hv_is(1'b1);
        @(posedge mclk) local_enable <= 1'b0;
        cyc(4);
        hv_is(1'b0);
        host.wr(OFS_CONTROL, 32'h1);
        cyc(1);
        hv_is(1'b1);
        host.wr(OFS_CONTROL, 32'h1 << CTL_OFF);
        @(posedge mclk) local_enable <= 1'b1;
        cyc(4);
        hv_is(1'b0);
        @(posedge mclk) local_enable <= 1'b0;
        // Each comparator fault; the next on command is the fault reset
        for (int i = 0; i < 6; i++) begin
            host.wr(OFS_CONTROL, 32'h1);
            @(posedge mclk) flt[i] <= 1'b1;
            cyc(4);
            hv_is(i == FLT_UC || i == FLT_OP);
            chk("lamps", lamps(), i == FLT_OP ? 32'hA : 32'h1 << i);
            chk("ps_fault", {31'h0, ps_fault_oe}, 32'h1);
            rd(OFS_FLAGS, 32'h1 << i);
            rd(OFS_CODE, {28'h0, CODES[i]});
            @(posedge mclk) flt[i] <= 1'b0;
            cyc(4);
        end
        // Interlock opening drops output and refuses a new on command
        host.wr(OFS_CONTROL, 32'h1);
        @(posedge mclk) interlock_closed <= 1'b0;
        cyc(4);
        hv_is(1'b0);
        rd(OFS_CODE, {28'h0, CODE_IL});
        host.wr(OFS_CONTROL, 32'h1);
        cyc(2);
        hv_is(1'b0);
        @(posedge mclk) interlock_closed <= 1'b1;
        cyc(4);
        host.wr(OFS_CONTROL, 32'h1);
        cyc(1);
        hv_is(1'b1);
        // Single arc: lamp pulse of 1000 ms, output stays on
        arc(1);
        cyc(4);
        hv_is(1'b1);
        chk("lamps", lamps(), 32'h20);
        rd(OFS_CODE, {28'h0, CODE_ARC});
        cyc(9750);
        chk("lamps", lamps(), 32'h20);
        cyc(600);
        chk("lamps", lamps(), 32'h0);
        // Three arcs keep running, the fourth inside the window trips
        arc(3);
        hv_is(1'b1);
        arc(1);
        hv_is(1'b0);
        chk("lamps", lamps(), 32'h20);
        rd(OFS_FLAGS, 32'h1 << FLT_ARC);
        rd(OFS_CODE, {28'h0, CODE_ARC});
        // Armed watchdog: 15 ms of silence is fine, 30 ms trips
        host.wr(OFS_CONTROL, 32'h1 | 32'h1 << CTL_ARM);
        cyc(150);
        hv_is(1'b1);
        cyc(150);
        hv_is(1'b0);
        rd(OFS_FLAGS, 32'h1 << FLT_WD);
        rd(OFS_CODE, {28'h0, CODE_WD});
        rd(OFS_STATUS, 32'h1E);
        host.wr(OFS_CONTROL, 32'h1 << CTL_DISARM);
        // Random readings, unmapped read, setpoint write, then reset in mid-run
        rv = {$urandom, $urandom};
        @(posedge mclk) {kv_reading, ma_reading, fil_reading, oil_reading} <= rv;
        for (int i = 0; i < 4; i++) begin
            rd(OFS_KV_RD + 8'(4 * i), {16'h0, rv[63 - 16 * i -: 16]});
        end
        rd(8'h30, 32'h0);
        host.wr(OFS_KV_SET, {16'h0, rv[15:0] | 16'h0001});
        host.wr(OFS_MA_SET, {16'h0, rv[31:16]});
        cyc(1);
        chk("set_out", {kv_setpoint, ma_setpoint}, {rv[15:0] | 16'h0001, rv[31:16]});
        rd(OFS_KV_SET, {16'h0, rv[15:0] | 16'h0001});
        @(posedge mclk) sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        cyc(2);
        chk("set", {kv_setpoint, ma_setpoint}, 32'h0);
        end_of_test();
    end
endmodule
